// ### serial_rx_slot_router_tb_top.sv
// Self-checking bench for the receive slot router: register port and routed lanes.
// Assumes srr_host_src supplies the frames; all clk-domain inputs change at falling clk.
`default_nettype none

module serial_rx_slot_router_tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct packed {
    logic [1:0] lane;
    logic [7:0] val;
    logic [1:0] fmt;
    logic [4:0] n;
  } srr_row_t;

  logic                    clk = 1'b0;
  logic                    rst = 1'b1;
  logic [7:0]              reg_addr = 8'h00;
  logic                    reg_wr = 1'b0;
  logic                    reg_rd = 1'b0;
  logic [7:0]              reg_wdata = 8'h00;
  logic [7:0]              reg_rdata;
  logic [1:0]              frame_format = 2'h0;
  logic                    bclk;
  logic                    fsync;
  logic                    sdin;
  srr_pkg::srr_out_t [2:0] lane_out;
  int                      pulses [3][3];
  int                      error_cnt = 0;
  int                      tests_run = 0;
  logic [7:0]              q;

  // Lane, route value, format, slots per half
  localparam srr_row_t ROWS [10] = '{
    '{2'h0, 8'h25, srr_pkg::FMT_TDM, 5'h06}, '{2'h0, 8'h40, srr_pkg::FMT_I2S, 5'h01},
    '{2'h0, 8'h70, srr_pkg::FMT_LJ, 5'h01},  '{2'h1, 8'h31, srr_pkg::FMT_I2S, 5'h02},
    '{2'h1, 8'h40, srr_pkg::FMT_LJ, 5'h01},  '{2'h1, 8'h61, srr_pkg::FMT_TDM, 5'h02},
    '{2'h2, 8'h30, srr_pkg::FMT_TDM, 5'h11}, '{2'h2, 8'h41, srr_pkg::FMT_LJ, 5'h02},
    '{2'h2, 8'h60, srr_pkg::FMT_I2S, 5'h01}, '{2'h0, 8'h01, srr_pkg::FMT_TDM, 5'h02}};

  // 250 MHz system clock
  always #2 clk = ~clk;

  srr_slot_router dut_u (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .frame_format(frame_format), .bclk(bclk),
    .fsync(fsync), .sdin(sdin), .lane_out(lane_out));

  srr_host_src partner_u (.bclk(bclk), .fsync(fsync), .sdin(sdin));

  ////////////////////////////////////////////////////////////////////////////////
  // Count valid pulses per lane and kind; a pulse stands one cycle
  always @(posedge clk) begin
    for (int i = 0; i < 3; i++) begin
      pulses[i][0] <= pulses[i][0] + int'(lane_out[i].dac_valid === 1'b1);
      pulses[i][1] <= pulses[i][1] + int'(lane_out[i].adc_valid === 1'b1);
      pulses[i][2] <= pulses[i][2] + int'(lane_out[i].link_valid === 1'b1);
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %0t ns: seen %h, expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_addr  = a;
    reg_wdata = d;
    reg_wr    = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
  endtask : wr

  // Called at a falling edge, so a read may follow a write back to back
  // Read data is taken a full cycle after the strobe drops; it holds until the next read
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    reg_addr = a;
    reg_rd   = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
    @(negedge clk);
    d = reg_rdata;
  endtask : rd

  // The link reset needs bclk edges, so the host clocks idle bits meanwhile
  task automatic do_reset();
    rst = 1'b1;
    fork
      partner_u.idle(4);
      repeat (20) @(negedge clk);
    join
    @(negedge clk);
    rst = 1'b0;
  endtask : do_reset

  task automatic run_row(input srr_row_t r, input int i);
    int          snap [3][3];
    logic [23:0] tag;
    logic [31:0] exp_w;
    logic [7:0]  a;
    a   = srr_pkg::ADDR_LANE6 + 8'(r.lane);
    tag = 24'ha5c300 + 24'(i);
    wr(a, r.val);
    frame_format = r.fmt;
    rd(a, q);
    chk(32'(q), 32'(r.val));
    snap = pulses;
    partner_u.frame(r.fmt, tag, int'(r.n));
    repeat (10) @(negedge clk);
    for (int l = 0; l < 3; l++) begin
      for (int k = 0; k < 3; k++) begin
        chk(32'(pulses[l][k] - snap[l][k]), 32'(l == r.lane && k == int'(r.val[6:5]) - 1));
      end
    end
    exp_w = (r.fmt == srr_pkg::FMT_TDM) ? {tag, 3'h0, r.val[4:0]} : {tag, 2'h0, r.val[4], 1'b0, r.val[3:0]};
    if (r.val[6:5] != 2'h0) chk(lane_out[r.lane].data, exp_w);
    wr(a, 8'h00);
  endtask : run_row

  task automatic wrap_up();
    $display("TB: checks %0d, errors %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : wrap_up

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence: table rows, then a mid-run reset and the register corner cases
  initial begin
    do_reset();
    for (int i = 0; i < 10; i++) run_row(ROWS[i], i);
    wr(srr_pkg::ADDR_LANE6, 8'h7f);
    wr(srr_pkg::ADDR_LANE8, 8'h7f);
    do_reset();
    chk(32'(lane_out), 32'h0);
    rd(srr_pkg::ADDR_LANE6, q);
    chk(32'(q), 32'h05);
    rd(srr_pkg::ADDR_LANE7, q);
    chk(32'(q), 32'h06);
    rd(srr_pkg::ADDR_LANE8, q);
    chk(32'(q), 32'h07);
    // Reserved bit is written on purpose here to prove it is not stored
    wr(srr_pkg::ADDR_LANE7, 8'hff);
    rd(srr_pkg::ADDR_LANE7, q);
    chk(32'(q), 32'h7f);
    wr(8'h30, 8'h55);
    rd(8'h30, q);
    chk(32'(q), 32'h00);
    rd(srr_pkg::ADDR_LANE6, q);
    chk(32'(q), 32'h05);
    wrap_up();
  end

  // Frames take about 180 us in all; 300 us means a hang
  initial begin
    #300000;
    error_cnt++;
    wrap_up();
  end
endmodule : serial_rx_slot_router_tb_top

`default_nettype wire

// ### srr_host_src.sv
// Model of the host audio controller that drives frames into the slot router.
// Assumes the bench calls frame and idle one at a time; the bit clock stands still between calls.
`default_nettype none

module srr_host_src (
  // Link pins toward the router
  output var logic bclk,
  output var logic fsync,
  output var logic sdin
);
  timeunit 1ns;
  timeprecision 1ps;

  logic idle_fs;

  // Lines start low and still
  initial begin
    bclk    = 1'b0;
    fsync   = 1'b0;
    sdin    = 1'b0;
    idle_fs = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // One bit time, 125 ns; lines change at the falling edge, well before the rise
  task automatic edge_out(input logic fs, input logic d);
    fsync = fs;
    sdin  = d;
    #62.5 bclk = 1'b1;
    #62.5 bclk = 1'b0;
  endtask : edge_out

  // Idle edges; data toggles so that a stale bit is never mistaken for a held one
  task automatic idle(input int n);
    repeat (n) edge_out(idle_fs, ~sdin);
  endtask : idle

  // Slot k of half h carries {tag, 2'h0, h, k}, MSB first
  task automatic frame(input logic [1:0] fmt, input logic [23:0] tag, input int n);
    int          halves;
    int          h;
    int          k;
    logic        fs;
    logic [31:0] w;
    halves  = (fmt == srr_pkg::FMT_TDM) ? 1 : 2;
    idle_fs = (fmt == srr_pkg::FMT_I2S);
    // Four idle edges let a new route cross into the link domain first
    idle(4);
    for (int t = 0; t < halves * n * 32; t++) begin
      h = t / (n * 32);
      k = (t % (n * 32)) / 32;
      w = {tag, 2'h0, h[0], k[4:0]};
      case (fmt)
        srr_pkg::FMT_TDM: fs = (t == 0);
        srr_pkg::FMT_LJ:  fs = (h == 0);
        default:          fs = (h != 0);
      endcase
      // I2S moves fsync one bit ahead of each half; that bit carries no data
      if ((fmt == srr_pkg::FMT_I2S) && ((t % (n * 32)) == 0)) edge_out(fs, ~sdin);
      edge_out(fs, w[31 - (t % 32)]);
    end
    idle(2);
  endtask : frame
endmodule : srr_host_src

`default_nettype wire

// ### srr_pkg.sv
// Shared constants and types for the receive slot router of the primary serial port.
// Assumes a register port with byte-wide data and 8-bit addresses, and a serial link
// that carries 32-bit slots, most significant bit first.
`default_nettype none

package srr_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Register map
  localparam logic [7:0] ADDR_LANE6 = 8'h2d;  // rx_lane6_route
  localparam logic [7:0] ADDR_LANE7 = 8'h2e;  // rx_lane7_route
  localparam logic [7:0] ADDR_LANE8 = 8'h2f;  // rx_lane8_route
  localparam logic [7:0] RST_LANE6  = 8'h05;
  localparam logic [7:0] RST_LANE7  = 8'h06;
  localparam logic [7:0] RST_LANE8  = 8'h07;

  // Field layout of a lane route register
  localparam int RSVD_BIT = 7;
  localparam int SRC_MSB  = 6;
  localparam int SRC_LSB  = 5;
  localparam int SLOT_MSB = 4;
  localparam int SLOT_LSB = 0;

  // Source selector codes
  localparam logic [1:0] SRC_OFF  = 2'h0;
  localparam logic [1:0] SRC_DAC  = 2'h1;
  localparam logic [1:0] SRC_ADC  = 2'h2;
  localparam logic [1:0] SRC_LINK = 2'h3;

  // Frame formats on the frame_format input
  localparam logic [1:0] FMT_TDM = 2'h0;
  localparam logic [1:0] FMT_I2S = 2'h1;
  localparam logic [1:0] FMT_LJ  = 2'h2;

  ////////////////////////////////////////////////////////////////////////////////
  // Frame timing
  localparam int          LANES     = 3;
  localparam int          WORD_W    = 32;
  localparam logic [4:0]  LAST_BIT  = 5'h1f;     // Final bit of a slot
  localparam logic [10:0] POS_PRE   = 11'h7ff;   // I2S delay bit, before bit 0
  localparam logic [10:0] POS_END   = 11'h400;   // Past the longest frame
  localparam logic [10:0] POS_FIRST = 11'h000;

  ////////////////////////////////////////////////////////////////////////////////
  // Types
  typedef struct packed {
    logic [1:0] src;
    logic [4:0] slot;
  } srr_cfg_t;

  typedef struct packed {
    logic [WORD_W-1:0] data;
    logic              dac_valid;
    logic              adc_valid;
    logic              link_valid;
  } srr_out_t;

  typedef struct packed {
    srr_cfg_t [LANES-1:0] cfg;
    logic [7:0]           rdata;
    logic                 cfg_tgl;
    logic                 cfg_pend;
    logic                 ack1;
    logic                 ack2;
    logic [1:0]           fmt;
    logic [LANES-1:0]     t1;
    logic [LANES-1:0]     t2;
    logic [LANES-1:0]     t3;
    srr_out_t [LANES-1:0] out;
  } srr_sys_t;

  typedef struct packed {
    logic                          c1;
    logic                          c2;
    logic                          c3;
    srr_cfg_t [LANES-1:0]          cfg;
    logic [1:0]                    fmt;
    logic                          fs_prev;
    logic [10:0]                   pos;
    logic                          right;
    logic [LANES-1:0][WORD_W-1:0]  shift;
    logic [LANES-1:0][WORD_W-1:0]  hold;
    logic [LANES-1:0][1:0]         hold_src;
    logic [LANES-1:0]              done_tgl;
  } srr_link_t;

endpackage : srr_pkg

`default_nettype wire

// ### srr_slot_router.sv
// Receive slot router for lanes 6, 7 and 8 of the primary serial port.
// Assumes bclk is the serial bit clock that also launches fsync and sdin, and that
// software changes a route only while that lane's traffic may be dropped.
//
// Summary of operation
// [RL1] Lane 6 selector bits 6:5; 0 disables, 1 routes slot to DAC lane 6.
// [RL2] Lane 6 selector 2 loops ADC channel 2 output, 3 carries companion device 1.
// [RL3] Lane 7 selector bits 6:5; 0 disables, 1 routes slot to DAC lane 7.
// [RL4] Lane 7 selector 2 loops ADC channel 3 output, 3 carries companion device 2.
// [RL5] Slot index bits 4:0; 0-15 pick TDM slot n or left half slot n.
// [RL6] Slot index 16-31 pick TDM slot n or right half slot n minus 16.
// [RL7] Lane 6 slot index resets to 5.
// [RL8] Lane 7 slot index resets to 6.
// [RL9] All source selectors reset to 0, lanes disabled until enabled.
// [RL10] Bit 7 of each route register reads zero; software keeps it zero.
// [RL11] Lane 7 route register sits at 0x2e and resets to 0x06.
// [RL12] Lane 8 route register sits at 0x2f and resets to 0x07.
// [RL13] Lane 8 selector: 1 DAC lane 8, 2 ADC channel 4 loop, 3 device 3.
// [RL14] Enabled lane captures its slot once a frame; disabled lane ignores it.
`default_nettype none

module srr_slot_router (
  // System clock and reset
  input  wire logic                  clk,
  input  wire logic                  rst,
  // Register port
  input  wire logic [7:0]            reg_addr,
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  input  wire logic [7:0]            reg_wdata,
  output var  logic [7:0]            reg_rdata,
  // Frame format, from logic on clk
  input  wire logic [1:0]            frame_format,
  // Primary serial port link
  input  wire logic                  bclk,
  input  wire logic                  fsync,
  input  wire logic                  sdin,
  // Routed words, index 0 is lane 6
  output var  srr_pkg::srr_out_t [2:0] lane_out
);

  ////////////////////////////////////////////////////////////////////////////////
  // State of both domains
  srr_pkg::srr_sys_t  s;
  srr_pkg::srr_sys_t  next_s;
  srr_pkg::srr_link_t l;
  srr_pkg::srr_link_t next_l;
  logic               lrst1;
  logic               lrst2;

  // Decode shared by the register port
  logic       reg_hit;
  logic [1:0] reg_idx;

  assign reg_hit = (reg_addr >= srr_pkg::ADDR_LANE6) && (reg_addr <= srr_pkg::ADDR_LANE8);
  assign reg_idx = 2'(reg_addr - srr_pkg::ADDR_LANE6);

  assign reg_rdata = s.rdata;
  assign lane_out  = s.out;

  ////////////////////////////////////////////////////////////////////////////////
  // System domain: registers, config launch, word hand-in
  always_comb begin
    logic chg;
    logic pend;
    chg    = 1'b0;
    pend   = 1'b0;
    next_s = s;
    // Route registers; bit 7 is not stored so it always reads zero
    if (reg_wr && reg_hit) begin
      next_s.cfg[reg_idx].src  = reg_wdata[srr_pkg::SRC_MSB:srr_pkg::SRC_LSB];    // [RL1] [RL3] [RL13]
      next_s.cfg[reg_idx].slot = reg_wdata[srr_pkg::SLOT_MSB:srr_pkg::SLOT_LSB];  // [RL5] [RL11] [RL12]
      chg = 1'b1;
    end
    // Read answers the next cycle; unmapped addresses read zero
    if (reg_rd) begin
      next_s.rdata = reg_hit ? {1'b0, s.cfg[reg_idx]} : 8'h00;  // [RL10]
    end
    // A format change is relaunched like a register write
    next_s.fmt = frame_format;
    if (frame_format != s.fmt) begin
      chg = 1'b1;
    end
    // Link echo of the toggle comes back through two flops
    next_s.ack1 = l.c3;
    next_s.ack2 = s.ack1;
    // A change waits while the previous one is still crossing, so two never cancel out
    // Limitation: a write during a crossing may be seen torn until the follow-up lands
    pend = s.cfg_pend | chg;
    if (pend && (s.ack2 == s.cfg_tgl)) begin
      next_s.cfg_tgl  = ~s.cfg_tgl;
      next_s.cfg_pend = 1'b0;
    end else begin
      next_s.cfg_pend = pend;
    end
    // Capture toggles: t1 feeds t2 only, t2 against t3 finds the edge
    next_s.t1 = l.done_tgl;
    next_s.t2 = s.t1;
    next_s.t3 = s.t2;
    for (int i = 0; i < srr_pkg::LANES; i++) begin
      next_s.out[i].dac_valid  = 1'b0;
      next_s.out[i].adc_valid  = 1'b0;
      next_s.out[i].link_valid = 1'b0;
      // The held word is stable for a whole frame, long after this edge
      if (s.t2[i] ^ s.t3[i]) begin
        next_s.out[i].data       = l.hold[i];                           // [RL14]
        next_s.out[i].dac_valid  = (l.hold_src[i] == srr_pkg::SRC_DAC);  // [RL1] [RL3] [RL13]
        next_s.out[i].adc_valid  = (l.hold_src[i] == srr_pkg::SRC_ADC);  // [RL2] [RL4] [RL13]
        next_s.out[i].link_valid = (l.hold_src[i] == srr_pkg::SRC_LINK); // [RL2] [RL4] [RL13]
      end
    end
  end

  // System register stage with defaults
  always_ff @(posedge clk) begin
    if (rst) begin
      s              <= '0;
      s.cfg[0].src   <= srr_pkg::RST_LANE6[srr_pkg::SRC_MSB:srr_pkg::SRC_LSB];    // [RL9]
      s.cfg[0].slot  <= srr_pkg::RST_LANE6[srr_pkg::SLOT_MSB:srr_pkg::SLOT_LSB];  // [RL7]
      s.cfg[1].src   <= srr_pkg::RST_LANE7[srr_pkg::SRC_MSB:srr_pkg::SRC_LSB];    // [RL9]
      s.cfg[1].slot  <= srr_pkg::RST_LANE7[srr_pkg::SLOT_MSB:srr_pkg::SLOT_LSB];  // [RL8] [RL11]
      s.cfg[2].src   <= srr_pkg::RST_LANE8[srr_pkg::SRC_MSB:srr_pkg::SRC_LSB];    // [RL9]
      s.cfg[2].slot  <= srr_pkg::RST_LANE8[srr_pkg::SLOT_MSB:srr_pkg::SLOT_LSB];  // [RL12]
    end else begin
      s <= next_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Link reset: bclk must run a few edges after rst for the link to clear
  always_ff @(posedge bclk) begin
    lrst1 <= rst;
    lrst2 <= lrst1;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Link domain: frame position, slot match, word capture
  always_comb begin
    logic        is_tdm;
    logic        is_i2s;
    logic        half_start;
    logic [10:0] cur_pos;
    logic        cur_right;
    logic        hit;
    half_start = 1'b0;
    cur_pos    = l.pos;
    cur_right  = l.right;
    hit        = 1'b0;
    is_tdm     = (l.fmt == srr_pkg::FMT_TDM);
    is_i2s     = (l.fmt == srr_pkg::FMT_I2S);
    next_l     = l;
    // Config word taken only on a toggle edge, well after it settled
    next_l.c1  = s.cfg_tgl;
    next_l.c2  = l.c1;
    next_l.c3  = l.c2;
    if (l.c2 ^ l.c3) begin
      next_l.cfg = s.cfg;
      next_l.fmt = s.fmt;
    end
    // TDM starts on fsync rise only; I2S and left-justified restart each half
    next_l.fs_prev = fsync;
    if (is_tdm) begin
      half_start = fsync & ~l.fs_prev;
    end else begin
      half_start = fsync ^ l.fs_prev;
    end
    // I2S data lags the fsync edge by one bit
    if (half_start) begin
      cur_pos   = is_i2s ? srr_pkg::POS_PRE : srr_pkg::POS_FIRST;
      cur_right = is_tdm ? 1'b0 : (is_i2s ? fsync : ~fsync);
    end else begin
      cur_pos   = (l.pos == srr_pkg::POS_END) ? l.pos : 11'(l.pos + 11'h001);
      cur_right = l.right;
    end
    next_l.pos   = cur_pos;
    next_l.right = cur_right;
    for (int i = 0; i < srr_pkg::LANES; i++) begin
      if (is_tdm) begin
        hit = ~cur_pos[10] && (cur_pos[9:5] == l.cfg[i].slot);  // [RL5] [RL6]
      end else begin
        hit = ~cur_pos[10] && ~cur_pos[9] && (cur_pos[8:5] == l.cfg[i].slot[3:0])
              && (cur_right == l.cfg[i].slot[4]);               // [RL5] [RL6]
      end
      // Disabled lanes leave their slot alone
      if (hit && (l.cfg[i].src != srr_pkg::SRC_OFF)) begin
        next_l.shift[i] = {l.shift[i][srr_pkg::WORD_W-2:0], sdin};  // [RL14]
        if (cur_pos[4:0] == srr_pkg::LAST_BIT) begin
          next_l.hold[i]     = {l.shift[i][srr_pkg::WORD_W-2:0], sdin};
          next_l.hold_src[i] = l.cfg[i].src;
          next_l.done_tgl[i] = ~l.done_tgl[i];                       // [RL14]
        end
      end
    end
  end

  // Link register stage; link copy of config starts at the same defaults
  always_ff @(posedge bclk) begin
    if (lrst2) begin
      l              <= '0;
      l.pos          <= srr_pkg::POS_END;
      l.cfg[0].src   <= srr_pkg::RST_LANE6[srr_pkg::SRC_MSB:srr_pkg::SRC_LSB];
      l.cfg[0].slot  <= srr_pkg::RST_LANE6[srr_pkg::SLOT_MSB:srr_pkg::SLOT_LSB];
      l.cfg[1].src   <= srr_pkg::RST_LANE7[srr_pkg::SRC_MSB:srr_pkg::SRC_LSB];
      l.cfg[1].slot  <= srr_pkg::RST_LANE7[srr_pkg::SLOT_MSB:srr_pkg::SLOT_LSB];
      l.cfg[2].src   <= srr_pkg::RST_LANE8[srr_pkg::SRC_MSB:srr_pkg::SRC_LSB];
      l.cfg[2].slot  <= srr_pkg::RST_LANE8[srr_pkg::SLOT_MSB:srr_pkg::SLOT_LSB];
    end else begin
      l <= next_l;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks on register defaults and access
  lane6_reset_a: assert property (@(posedge clk) disable iff (rst)  // [RL7]
    $fell(rst) |-> (s.cfg[0] == srr_pkg::RST_LANE6[6:0]))
    else $error("lane6 route not at reset value");

  lane7_reset_a: assert property (@(posedge clk) disable iff (rst)  // [RL8]
    $fell(rst) |-> ({1'b0, s.cfg[1]} == srr_pkg::RST_LANE7))
    else $error("lane7 route not at reset value");

  lane8_reset_a: assert property (@(posedge clk) disable iff (rst)  // [RL12]
    $fell(rst) |-> ({1'b0, s.cfg[2]} == srr_pkg::RST_LANE8))
    else $error("lane8 route not at reset value");

  src_reset_a: assert property (@(posedge clk) disable iff (rst)  // [RL9]
    $fell(rst) |-> (s.cfg[0].src == srr_pkg::SRC_OFF) && (s.cfg[1].src == srr_pkg::SRC_OFF)
                   && (s.cfg[2].src == srr_pkg::SRC_OFF))
    else $error("source selector not disabled after reset");

  rsvd_zero_a: assert property (@(posedge clk) disable iff (rst)  // [RL10]
    reg_rd |=> (reg_rdata[srr_pkg::RSVD_BIT] == 1'b0))
    else $error("reserved bit read as one");

  // Write to lane 7, read it back the next cycle, and check the data two cycles on
  sequence lane7_write_s;
    reg_wr && !reg_rd && (reg_addr == 8'h2e);
  endsequence

  sequence lane7_readback_s;
    ##1 (reg_rd && !reg_wr && (reg_addr == 8'h2e)) ##1 1'b1;
  endsequence

  lane7_write_a: assert property (@(posedge clk) disable iff (rst)  // [RL11]
    lane7_write_s ##0 lane7_readback_s |-> (reg_rdata == {1'b0, $past(reg_wdata[6:0], 2)}))
    else $error("lane7 route write not read back");

  lane8_read_a: assert property (@(posedge clk) disable iff (rst)  // [RL12]
    (reg_rd && !reg_wr && (reg_addr == 8'h2f)) |=> (reg_rdata == {1'b0, $past(s.cfg[2])}))
    else $error("lane8 route read mismatch");

  unmapped_a: assert property (@(posedge clk) disable iff (rst)  // [RL11] [RL12]
    (reg_rd && ((reg_addr == 8'h2c) || (reg_addr == 8'h30))) |=> (reg_rdata == 8'h00))
    else $error("unmapped address did not read zero");

  rdata_hold_a: assert property (@(posedge clk) disable iff (rst)  // [RL10]
    !reg_rd |=> $stable(reg_rdata))
    else $error("read data changed without a read");

  unmapped_wr_a: assert property (@(posedge clk) disable iff (rst)  // [RL11] [RL12]
    (reg_wr && !reg_hit) |=> (s.cfg == $past(s.cfg)))
    else $error("unmapped write changed a route");

  ////////////////////////////////////////////////////////////////////////////////
  // Checks on the route hand-over into the link domain
  // A toggle during a crossing would let two changes cancel and strand the link
  tgl_hold_a: assert property (@(posedge clk) disable iff (rst)  // [RL14]
    (s.ack2 != s.cfg_tgl) |=> (s.cfg_tgl == $past(s.cfg_tgl)))
    else $error("route toggled while a hand-over was in flight");

  pend_send_a: assert property (@(posedge clk) disable iff (rst)  // [RL14]
    (s.cfg_pend && (s.ack2 == s.cfg_tgl)) |=> (s.cfg_tgl != $past(s.cfg_tgl)))
    else $error("pending route change never sent");

  // Past the longest frame the position parks until the next frame start
  pos_stop_a: assert property (@(posedge bclk) disable iff (lrst2)  // [RL14]
    ((l.pos == srr_pkg::POS_END) && (fsync == l.fs_prev)) |=> (l.pos == srr_pkg::POS_END))
    else $error("frame position left its parked value");

  ////////////////////////////////////////////////////////////////////////////////
  // Checks on capture and hand-over per lane
  for (genvar g = 0; g < 3; g++) begin : g_chk
    sequence word_caught_s;
      $changed(l.done_tgl[g]);
    endsequence

    sequence word_shown_s;
      ##[1:4] (s.out[g].dac_valid || s.out[g].adc_valid || s.out[g].link_valid);
    endsequence

    handoff_a: assert property (@(posedge clk) disable iff (rst)  // [RL14]
      word_caught_s |-> word_shown_s)
      else $error("captured word never presented");

    dest_match_a: assert property (@(posedge clk) disable iff (rst)  // [RL1] [RL2] [RL3] [RL4] [RL13]
      (s.t2[g] ^ s.t3[g]) |=> (s.out[g].dac_valid == (l.hold_src[g] == 2'h1))
                              && (s.out[g].adc_valid == (l.hold_src[g] == 2'h2))
                              && (s.out[g].link_valid == (l.hold_src[g] == 2'h3)))
      else $error("word presented to wrong destination");

    capture_on_a: assert property (@(posedge bclk) disable iff (lrst2)  // [RL14]
      $changed(l.done_tgl[g]) |-> (l.hold_src[g] != 2'h0) && (l.pos[4:0] == 5'h1f))
      else $error("capture from disabled lane or mid slot");

    tdm_slot_a: assert property (@(posedge bclk) disable iff (lrst2)  // [RL5] [RL6]
      ($changed(l.done_tgl[g]) && (l.fmt == 2'h0)) |-> (l.pos[9:5] == l.cfg[g].slot))
      else $error("tdm capture in wrong slot");

    half_slot_a: assert property (@(posedge bclk) disable iff (lrst2)  // [RL5] [RL6]
      ($changed(l.done_tgl[g]) && (l.fmt != 2'h0))
        |-> (l.right == l.cfg[g].slot[4]) && (l.pos[8:5] == l.cfg[g].slot[3:0]))
      else $error("half-frame capture in wrong slot");

    // One destination per word, one cycle per pulse
    valid_onehot_a: assert property (@(posedge clk) disable iff (rst)  // [RL1] [RL2] [RL3] [RL4] [RL13]
      $onehot0({s.out[g].dac_valid, s.out[g].adc_valid, s.out[g].link_valid}))
      else $error("word presented to two destinations");

    valid_pulse_a: assert property (@(posedge clk) disable iff (rst)  // [RL14]
      (s.out[g].dac_valid || s.out[g].adc_valid || s.out[g].link_valid)
        |=> !(s.out[g].dac_valid || s.out[g].adc_valid || s.out[g].link_valid))
      else $error("valid pulse longer than one cycle");

    // The word stands until the next capture of that lane
    data_hold_a: assert property (@(posedge clk) disable iff (rst)  // [RL14]
      !(s.t2[g] ^ s.t3[g]) |=> $stable(s.out[g].data))
      else $error("lane word changed without a capture");
  end

endmodule : srr_slot_router

`default_nettype wire
